/* logic/bpwu_cmp.sv */
// Module: one address comparator shared by breakpoint and watchpoint units
`timescale 1ns/1ps
`default_nettype none
module bpwu_cmp #(
  parameter int LANES = 4,
  parameter int LSB   = 2
) (
  input  wire logic             en_i,        // Unit enabled, access valid
  input  wire logic [1:0]       priv_sel_i,  // Privilege match field
  input  wire logic             acc_priv_i,  // Access is privileged
  input  wire logic             type_ok_i,   // Access type allowed
  input  wire logic [31:0]      val_i,       // Programmed address
  input  wire logic [LANES-1:0] lane_sel_i,  // Selected byte lanes
  input  wire logic [31:0]      addr_i,      // Access address
  input  wire logic [LANES-1:0] lane_acc_i,  // Lanes touched by access
  input  wire logic             mismatch_i,  // Invert the address sense
  output logic                  match_o,     // Raw address and lane match
  output logic                  hit_o        // Qualified debug event
);
  // Address compare above the ignored low bits
  wire logic addr_eq  = (addr_i[31:LSB] == val_i[31:LSB]);
  // At least one selected lane is touched
  wire logic lane_hit = |(lane_sel_i & lane_acc_i);
  // Privilege field: bit 0 privileged, bit 1 user
  wire logic priv_ok  = acc_priv_i ? priv_sel_i[0] : priv_sel_i[1];

  assign match_o = addr_eq & lane_hit;
  // Mismatch fires anywhere but the programmed address
  assign hit_o = en_i & priv_ok & type_ok_i
               & (mismatch_i ? ~match_o : match_o);
endmodule : bpwu_cmp
`default_nettype wire

/* logic/bpwu_pkg.sv */
// Package: constants and carriers for the breakpoint and watchpoint units
// How it works
// - Breakpoint value is word aligned, low bits ignored
// - Breakpoint byte lanes select matched bytes
// - Enable bit and privilege field gate breakpoints
// - Meaning value four makes an address-mismatch breakpoint
// - Only mismatch-capable units step off an instruction
// - Mismatch stays silent while execution stays put
// - Recursive returns to same address stay silent
// - Watchpoint value is doubleword aligned
// - Eight watchpoint lanes, one per doubleword byte
// - Access type field, store-only watches writes
// - Watchpoint enable, privilege and breakpoint linking
// - Unaligned object inside one doubleword needs one unit
// - Register number times four gives byte offset
`default_nettype none
package bpwu_pkg;
  localparam int NUM_BP = 8;          // Breakpoint units
  localparam int NUM_WP = 8;          // Watchpoint units
  localparam int NUM_MM = 2;          // Units able to mismatch
  localparam int BP_LSB = 2;          // Ignored low address bits, bkpt
  localparam int WP_LSB = 3;          // Ignored low address bits, watch
  localparam int BP_LANES = 4;        // Byte lanes per breakpoint
  localparam int WP_LANES = 8;        // Byte lanes per watchpoint
  // Register number groups (number = group * 16 + unit)
  localparam logic [3:0] GRP_BVR = 4'h4;  // Numbers 64..79
  localparam logic [3:0] GRP_BCR = 4'h5;  // Numbers 80..95
  localparam logic [3:0] GRP_WVR = 4'h6;  // Numbers 96..111
  localparam logic [3:0] GRP_WCR = 4'h7;  // Numbers 112..127
  // Stored-bit masks; masked bits read as zero
  localparam logic [31:0] BVR_MASK  = 32'hffff_fffc;
  localparam logic [31:0] WVR_MASK  = 32'hffff_fff8;
  localparam logic [31:0] BCR_WMASK = 32'h007f_01e7;
  localparam logic [31:0] WCR_WMASK = 32'h001f_1fff;
  localparam logic [31:0] MEAN_BITS = 32'h0070_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Field positions
  localparam int CTL_EN      = 0;
  localparam int CTL_PRIV_LO = 1;
  localparam int WCR_TYPE_LO = 3;
  localparam int CTL_BAS_LO  = 5;
  localparam int CTL_LINK_LO = 16;
  localparam int WCR_LINK_EN = 20;
  localparam int BCR_MEAN_LO = 20;
  // Field encodings
  localparam logic [2:0] MEAN_MATCH    = 3'h0;
  localparam logic [2:0] MEAN_MISMATCH = 3'h4;
  localparam logic [1:0] PRIV_ANY      = 2'h3;
  localparam logic [1:0] TYPE_STORE    = 2'h2;
  // Retired instruction seen by the breakpoint units
  typedef struct packed {
    logic        valid;  // Instruction address presented
    logic [31:0] addr;   // Instruction address
    logic        half;   // Sixteen-bit instruction
    logic        priv;   // Privileged mode
  } bpwu_iacc_t;
  // Data access seen by the watchpoint units
  typedef struct packed {
    logic        valid;  // Access presented
    logic [31:0] addr;   // Byte address
    logic        write;  // Store when set
    logic [1:0]  size;   // 0:1, 1:2, 2:4, 3:8 bytes
    logic        priv;   // Privileged mode
  } bpwu_dacc_t;
endpackage : bpwu_pkg
`default_nettype wire

/* logic/bpwu_top.sv */
// Module: breakpoint and watchpoint units with their debug registers
`timescale 1ns/1ps
`default_nettype none
module bpwu_top (
  input  wire logic                       sys_clk_i,   // Processor clock
  input  wire logic                       rst_i,       // Sync reset
  input  wire logic [9:0]                 reg_addr_i,  // Byte address
  input  wire logic                       reg_wr_i,    // Write strobe
  input  wire logic                       reg_rd_i,    // Read strobe
  input  wire logic [31:0]                reg_wdata_i, // Write data
  output logic      [31:0]                reg_rdata_o, // Read data
  output logic                            reg_ack_o,   // Access done
  input  wire bpwu_pkg::bpwu_iacc_t       iacc_i,      // Instruction
  input  wire bpwu_pkg::bpwu_dacc_t       dacc_i,      // Data access
  output logic [bpwu_pkg::NUM_BP-1:0]     bp_hit_o,    // Per-unit hits
  output logic [bpwu_pkg::NUM_WP-1:0]     wp_hit_o,    // Per-unit hits
  output logic                            bp_event_o,  // Any breakpoint
  output logic                            wp_event_o   // Any watchpoint
);
  // Register storage
  logic [31:0] bvr_r [bpwu_pkg::NUM_BP];  // Breakpoint values
  logic [31:0] bcr_r [bpwu_pkg::NUM_BP];  // Breakpoint controls
  logic [31:0] wvr_r [bpwu_pkg::NUM_WP];  // Watchpoint values
  logic [31:0] wcr_r [bpwu_pkg::NUM_WP];  // Watchpoint controls

  // Register number decode: byte offset is number times four
  wire logic [7:0] reg_num = reg_addr_i[9:2];
  wire logic [3:0] grp     = reg_num[7:4];     // Register group
  wire logic [3:0] unit    = reg_num[3:0];     // Unit index
  wire logic [2:0] unit3   = unit[2:0];        // Index into arrays
  wire logic       bp_ok   = (unit < 4'(bpwu_pkg::NUM_BP));
  wire logic       wp_ok   = (unit < 4'(bpwu_pkg::NUM_WP));
  wire logic sel_bvr = (grp == bpwu_pkg::GRP_BVR) & bp_ok;
  wire logic sel_bcr = (grp == bpwu_pkg::GRP_BCR) & bp_ok;
  wire logic sel_wvr = (grp == bpwu_pkg::GRP_WVR) & wp_ok;
  wire logic sel_wcr = (grp == bpwu_pkg::GRP_WCR) & wp_ok;
  wire logic wr_bvr  = reg_wr_i & sel_bvr;
  wire logic wr_bcr  = reg_wr_i & sel_bcr;
  wire logic wr_wvr  = reg_wr_i & sel_wvr;
  wire logic wr_wcr  = reg_wr_i & sel_wcr;
  // Units past the mismatch-capable ones drop the meaning field
  wire logic [31:0] bcr_mask = (unit < 4'(bpwu_pkg::NUM_MM))
    ? bpwu_pkg::BCR_WMASK
    : (bpwu_pkg::BCR_WMASK & ~bpwu_pkg::MEAN_BITS);
  // Read selection; unmapped numbers read as zero
  wire logic [31:0] rd_val =
      sel_bvr ? bvr_r[unit3] :
      sel_bcr ? bcr_r[unit3] :
      sel_wvr ? wvr_r[unit3] :
      sel_wcr ? wcr_r[unit3] : bpwu_pkg::REG_RESET;

  // Register writes; low address bits are forced to zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < bpwu_pkg::NUM_BP; i++) begin
        bvr_r[i] <= bpwu_pkg::REG_RESET;
        bcr_r[i] <= bpwu_pkg::REG_RESET;
      end
      for (int i = 0; i < bpwu_pkg::NUM_WP; i++) begin
        wvr_r[i] <= bpwu_pkg::REG_RESET;
        wcr_r[i] <= bpwu_pkg::REG_RESET;
      end
    end else begin
      // Writing zero to a control disables that unit at once
      if (wr_bvr) begin
        bvr_r[unit3] <= reg_wdata_i & bpwu_pkg::BVR_MASK;
      end
      if (wr_bcr) begin
        bcr_r[unit3] <= reg_wdata_i & bcr_mask;
      end
      if (wr_wvr) begin
        wvr_r[unit3] <= reg_wdata_i & bpwu_pkg::WVR_MASK;
      end
      if (wr_wcr) begin
        wcr_r[unit3] <= reg_wdata_i & bpwu_pkg::WCR_WMASK;
      end
    end
  end

  // Read data and acknowledge, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= bpwu_pkg::REG_RESET;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_val : bpwu_pkg::REG_RESET;
      reg_ack_o   <= reg_rd_i | reg_wr_i;
    end
  end

  // Instruction byte lanes: half-word instructions use one half
  wire logic [3:0] ilanes = iacc_i.half
    ? (4'h3 << {iacc_i.addr[1], 1'b0}) : 4'hf;
  // Data byte lanes from size and offset inside the doubleword
  wire logic [7:0] dsize  = (dacc_i.size == 2'h0) ? 8'h01 :
                            (dacc_i.size == 2'h1) ? 8'h03 :
                            (dacc_i.size == 2'h2) ? 8'h0f : 8'hff;
  // Bytes past the doubleword fall outside this unit
  wire logic [7:0] dlanes = dsize << dacc_i.addr[2:0];

  logic [bpwu_pkg::NUM_BP-1:0] bp_match;  // Raw address matches
  logic [bpwu_pkg::NUM_BP-1:0] bp_hit;    // Qualified hits
  logic [bpwu_pkg::NUM_WP-1:0] wp_hit;    // Qualified hits
  wire logic [15:0] bp_match_pad = 16'(bp_match);  // Link lookup

  // Breakpoint units
  for (genvar i = 0; i < bpwu_pkg::NUM_BP; i++) begin : g_bp
    wire logic [2:0] mean = bcr_r[i][bpwu_pkg::BCR_MEAN_LO +: 3];
    // Meaning four inverts the compare
    wire logic mm = (mean == bpwu_pkg::MEAN_MISMATCH);
    // Unsupported meanings never fire
    wire logic mean_ok = (mean == bpwu_pkg::MEAN_MATCH) | mm;
    bpwu_cmp #(.LANES(bpwu_pkg::BP_LANES), .LSB(bpwu_pkg::BP_LSB)) u_cmp (
      .en_i       (iacc_i.valid & bcr_r[i][bpwu_pkg::CTL_EN] & mean_ok),
      .priv_sel_i (bcr_r[i][bpwu_pkg::CTL_PRIV_LO +: 2]),
      .acc_priv_i (iacc_i.priv),
      .type_ok_i  (1'b1),
      .val_i      (bvr_r[i]),
      .lane_sel_i (bcr_r[i][bpwu_pkg::CTL_BAS_LO +: bpwu_pkg::BP_LANES]),
      .addr_i     (iacc_i.addr),
      .lane_acc_i (ilanes),
      .mismatch_i (mm),
      .match_o    (bp_match[i]),
      .hit_o      (bp_hit[i])
    );
  end

  // Watchpoint units
  for (genvar i = 0; i < bpwu_pkg::NUM_WP; i++) begin : g_wp
    wire logic [1:0] wtype = wcr_r[i][bpwu_pkg::WCR_TYPE_LO +: 2];
    // Type bit 1 allows stores, bit 0 loads
    wire logic type_ok = dacc_i.write ? wtype[1] : wtype[0];
    wire logic [3:0] lidx = wcr_r[i][bpwu_pkg::CTL_LINK_LO +: 4];
    // Linked unit must match the issuing instruction
    wire logic link_ok = ~wcr_r[i][bpwu_pkg::WCR_LINK_EN]
                       | bp_match_pad[lidx];
    bpwu_cmp #(.LANES(bpwu_pkg::WP_LANES), .LSB(bpwu_pkg::WP_LSB)) u_cmp (
      .en_i       (dacc_i.valid & wcr_r[i][bpwu_pkg::CTL_EN]),
      .priv_sel_i (wcr_r[i][bpwu_pkg::CTL_PRIV_LO +: 2]),
      .acc_priv_i (dacc_i.priv),
      .type_ok_i  (type_ok & link_ok),
      .val_i      (wvr_r[i]),
      .lane_sel_i (wcr_r[i][bpwu_pkg::CTL_BAS_LO +: bpwu_pkg::WP_LANES]),
      .addr_i     (dacc_i.addr),
      .lane_acc_i (dlanes),
      .mismatch_i (1'b0),
      .match_o    (),
      .hit_o      (wp_hit[i])
    );
  end

  // Debug event outputs, registered
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bp_hit_o   <= '0;
      wp_hit_o   <= '0;
      bp_event_o <= 1'b0;
      wp_event_o <= 1'b0;
    end else begin
      bp_hit_o   <= bp_hit;
      wp_hit_o   <= wp_hit;
      bp_event_o <= |bp_hit;
      wp_event_o <= |wp_hit;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Unit 0 set up for stepping in any privilege level
  wire logic mm0 = bcr_r[0][bpwu_pkg::CTL_EN]
    & (bcr_r[0][bpwu_pkg::BCR_MEAN_LO +: 3] == bpwu_pkg::MEAN_MISMATCH)
    & (bcr_r[0][bpwu_pkg::CTL_PRIV_LO +: 2] == bpwu_pkg::PRIV_ANY);
  wire logic at0 = iacc_i.addr[31:2] == bvr_r[0][31:2];
  wire logic wstore0 = wcr_r[0][bpwu_pkg::CTL_EN]
    & (wcr_r[0][bpwu_pkg::WCR_TYPE_LO +: 2] == bpwu_pkg::TYPE_STORE);

  sequence s_wr_bvr;
    wr_bvr;
  endsequence
  sequence s_wr_wvr;
    wr_wvr;
  endsequence
  sequence s_mm_leave;
    iacc_i.valid & mm0 & ~at0;
  endsequence

  bvr_aligned_a: assert property (
    s_wr_bvr |=> bvr_r[$past(unit3)][1:0] == 2'h0)
    else $error("breakpoint value low bits not zero");
  wvr_aligned_a: assert property (
    s_wr_wvr |=> wvr_r[$past(unit3)][2:0] == 3'h0)
    else $error("watchpoint value low bits not zero");
  mm_fire_a: assert property (
    s_mm_leave |=> bp_hit_o[0] && bp_event_o)
    else $error("mismatch unit did not fire off address");
  mm_stay_a: assert property (
    iacc_i.valid & mm0 & at0 & ~iacc_i.half
      & (bcr_r[0][bpwu_pkg::CTL_BAS_LO +: 4] == 4'hf) |=> !bp_hit_o[0])
    else $error("mismatch unit fired at programmed address");
  mm_capable_a: assert property (
    bcr_r[bpwu_pkg::NUM_BP-1][bpwu_pkg::BCR_MEAN_LO +: 3] == 3'h0)
    else $error("incapable unit holds a meaning value");
  // Unit 3 cannot hold a meaning, so every hit there is a plain match
  bp_lane_a: assert property (
    bp_hit_o[3]
      |-> $past(|(bcr_r[3][bpwu_pkg::CTL_BAS_LO +: 4] & ilanes)))
    else $error("breakpoint hit without a selected lane");
  wp_store_a: assert property (
    wstore0 & dacc_i.valid & ~dacc_i.write |=> !wp_hit_o[0])
    else $error("store-only watchpoint fired on a load");
  wp_lane_a: assert property (
    wp_hit_o[0] |-> $past(|(wcr_r[0][bpwu_pkg::CTL_BAS_LO +: 8] & dlanes)))
    else $error("watchpoint hit without a selected lane");
  wp_link_a: assert property (
    wcr_r[5][bpwu_pkg::WCR_LINK_EN]
      & ~bp_match_pad[wcr_r[5][bpwu_pkg::CTL_LINK_LO +: 4]]
      |=> !wp_hit_o[5])
    else $error("linked watchpoint fired without its breakpoint");
  bus_ack_a: assert property (
    reg_rd_i && !(sel_bvr | sel_bcr | sel_wvr | sel_wcr)
      |=> reg_ack_o && reg_rdata_o == 32'h0000_0000)
    else $error("unmapped read not answered with zero");
endmodule : bpwu_top
`default_nettype wire

/* tb/bpwu_dbg.sv */
// Debugger model that programs the units over the register port
`timescale 1ns/1ps
`default_nettype none
module bpwu_dbg (
  input  wire logic        sys_clk_i,   // Processor clock
  output logic [9:0]       reg_addr_o,  // Byte address
  output logic             reg_wr_o,    // Write strobe
  output logic             reg_rd_o,    // Read strobe
  output logic [31:0]      reg_wdata_o, // Write data
  input  wire logic [31:0] reg_rdata_i, // Read data
  input  wire logic        reg_ack_i,   // Access done
  output logic             bus_to_o     // Acknowledge went missing
);
  // Idle bus at time zero
  initial begin
    reg_addr_o = 10'h3ff;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 32'h0;
    bus_to_o = 1'b0;
  end
  // One strobe cycle; the answer stands in the following cycle
  task automatic xfer(input logic w, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk_i);
    reg_wr_o <= w;
    reg_rd_o <= !w;
    reg_addr_o <= 10'(n * 4);
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~reg_addr_o;  // Released lines do not hold
    reg_wdata_o <= ~d;
    @(negedge sys_clk_i);
    q = reg_rdata_i;
    if (reg_ack_i !== 1'b1)
      bus_to_o = 1'b1;
  endtask : xfer
  // Register write
  task automatic wr(input int n, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, n, d, q);
  endtask : wr
  // Register read
  task automatic rd(input int n, output logic [31:0] q);
    xfer(1'b0, n, 32'h0, q);
  endtask : rd
  // Disable, load address, then enable with lanes from the address
  task automatic set_bp(input int u, input logic [31:0] a, input logic h,
                        input logic [2:0] mean);
    logic [3:0] ln;
    ln = h ? (a[1] ? 4'hc : 4'h3) : 4'hf;
    wr(80 + u, 32'h0);
    wr(64 + u, a & 32'hffff_fffc);
    wr(80 + u, {9'h0, mean, 11'h0, ln, 5'h07});
  endtask : set_bp
  // Store watch over sz bytes; spills into the next unit when needed
  task automatic set_wp(input int u, input logic [31:0] a, input int sz,
                        input logic [31:0] ext);
    logic [15:0] ln;
    ln = 16'((1 << sz) - 1) << a[2:0];
    wr(112 + u, 32'h0);
    wr(96 + u, {a[31:3], 3'h0});
    wr(112 + u, 32'h17 | {19'h0, ln[7:0], 5'h0} | ext);
    if (ln[15:8] != 8'h0) begin
      wr(113 + u, 32'h0);
      wr(97 + u, {a[31:3], 3'h0} + 32'h8);
      wr(113 + u, 32'h17 | {19'h0, ln[15:8], 5'h0});
    end
  endtask : set_wp
endmodule : bpwu_dbg
`default_nettype wire

/* tb/bpwu_top_tb.sv */
// Self-checking bench for the breakpoint and watchpoint units
`timescale 1ns/1ps
`default_nettype none
module bpwu_top_tb;
  logic                 sys_clk = 1'b0;  // 50 MHz clock
  logic                 rst;             // Sync reset
  logic [9:0]           addr;            // Register port
  logic                 wr;
  logic                 rd;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  logic                 ack;
  logic                 bus_to;          // Missing acknowledge
  bpwu_pkg::bpwu_iacc_t iacc;            // Instruction stream
  bpwu_pkg::bpwu_dacc_t dacc;            // Data stream
  logic [7:0]           bp_hit;
  logic [7:0]           wp_hit;
  logic                 bp_ev;
  logic                 wp_ev;
  int                   fails = 0;
  int                   n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  bpwu_top bpwu_top_inst (.sys_clk_i(sys_clk), .rst_i(rst),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .iacc_i(iacc), .dacc_i(dacc),
    .bp_hit_o(bp_hit), .wp_hit_o(wp_hit), .bp_event_o(bp_ev),
    .wp_event_o(wp_ev));
  bpwu_dbg bpwu_dbg_inst (.sys_clk_i(sys_clk), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata), .reg_ack_i(ack), .bus_to_o(bus_to));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Counts and verdict
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  // Hang guards: lost acknowledge or overall cycle budget
  always @(posedge sys_clk) if (bus_to) begin
    fails++;
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    finish_test();
  end
  // Packed access builders
  function automatic logic [34:0] ifx(logic [31:0] a, logic h, logic p);
    return {1'b1, a, h, p};
  endfunction : ifx
  function automatic logic [36:0] dx(logic [31:0] a, logic w, logic [1:0] s);
    return {1'b1, a, w, s, 1'b1};
  endfunction : dx
  // Present one cycle of accesses and check the hits one cycle later
  task automatic acc(input logic [34:0] ia, input logic [36:0] da,
                     input logic [7:0] eb, input logic [7:0] ew);
    @(posedge sys_clk);
    iacc <= ia;
    dacc <= da;
    @(posedge sys_clk);
    iacc.valid <= 1'b0;
    dacc.valid <= 1'b0;
    @(negedge sys_clk);
    chk({bp_hit, wp_hit, 14'h0, bp_ev, wp_ev},
        {eb, ew, 14'h0, |eb, |ew});
  endtask : acc
  // Register read and compare
  task automatic rdc(input int n, input logic [31:0] e);
    logic [31:0] q;
    bpwu_dbg_inst.rd(n, q);
    chk(q, e);
  endtask : rdc
  // Reset values, stored-bit masks and unmapped numbers
  task automatic t_regs;
    int          n[7] = '{70, 80, 87, 102, 118, 72, 127};
    logic [31:0] e[7] = '{32'hffff_fffc, 32'h007f_01e7, 32'h000f_01e7,
                          32'hffff_fff8, 32'h001f_1fff, 32'h0, 32'h0};
    rdc(81, 32'h0);
    rdc(119, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bpwu_dbg_inst.wr(n[i], 32'hffff_ffff);
      rdc(n[i], e[i]);
      bpwu_dbg_inst.wr(n[i], 32'h0);
    end
  endtask : t_regs
  // Word and half-word breakpoints, lanes and privilege
  task automatic t_bp;
    bpwu_dbg_inst.set_bp(1, 32'h1000, 1'b0, 3'h0);
    bpwu_dbg_inst.set_bp(3, 32'h2002, 1'b1, 3'h0);
    acc(ifx(32'h1000, 0, 1), 37'h0, 8'h02, 8'h0);
    acc(ifx(32'h1003, 0, 1), 37'h0, 8'h02, 8'h0);
    acc(ifx(32'h1004, 0, 1), 37'h0, 8'h00, 8'h0);
    acc(ifx(32'h2002, 1, 1), 37'h0, 8'h08, 8'h0);
    acc(ifx(32'h2000, 1, 1), 37'h0, 8'h00, 8'h0);
    acc(ifx(32'h2000, 0, 1), 37'h0, 8'h08, 8'h0);
    bpwu_dbg_inst.wr(81, 32'h0);
    bpwu_dbg_inst.wr(81, 32'h0000_01e3);
    acc(ifx(32'h1000, 0, 0), 37'h0, 8'h00, 8'h0);
    acc(ifx(32'h1000, 0, 1), 37'h0, 8'h02, 8'h0);
  endtask : t_bp
  // Store watches: lanes, access type, spill and linking
  task automatic t_wp;
    bpwu_dbg_inst.set_wp(0, 32'ha003, 4, 32'h0);
    acc(35'h0, dx(32'ha000, 1, 0), 8'h0, 8'h00);
    acc(35'h0, dx(32'ha004, 1, 0), 8'h0, 8'h01);
    acc(35'h0, dx(32'ha004, 0, 0), 8'h0, 8'h00);
    acc(35'h0, dx(32'ha000, 1, 3), 8'h0, 8'h01);
    bpwu_dbg_inst.set_wp(2, 32'h900f, 2, 32'h0);
    acc(35'h0, dx(32'h900f, 1, 0), 8'h0, 8'h04);
    acc(35'h0, dx(32'h9010, 1, 0), 8'h0, 8'h08);
    acc(35'h0, dx(32'h900e, 1, 0), 8'h0, 8'h00);
    bpwu_dbg_inst.set_wp(5, 32'hc000, 4, 32'h0011_0000);
    acc(ifx(32'h1000, 0, 1), dx(32'hc000, 1, 2), 8'h02, 8'h20);
    acc(ifx(32'h1004, 0, 1), dx(32'hc000, 1, 2), 8'h00, 8'h00);
    // Load and store watch over a whole doubleword, hit by a load
    bpwu_dbg_inst.set_wp(6, 32'hd000, 8, 32'h0000_0008);
    acc(35'h0, dx(32'hd000, 0, 3), 8'h0, 8'h40);
  endtask : t_wp
  // Mismatch stepping, only on capable units; halt mode taken as set up
  task automatic t_mm;
    bpwu_dbg_inst.set_bp(0, 32'h3000, 1'b0, 3'h4);
    bpwu_dbg_inst.set_bp(2, 32'h3000, 1'b0, 3'h4);
    // Repeated returns to the stepped address leave unit 0 silent; unit 2 hits as a plain match
    repeat (3) begin
      acc(ifx(32'h3000, 0, 1), 37'h0, 8'h04, 8'h0);
    end
    acc(ifx(32'h3004, 0, 1), 37'h0, 8'h01, 8'h0);
  endtask : t_mm
  // Main sequence
  initial begin
    rst = 1'b1;
    iacc = '0;
    dacc = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_bp();
    t_wp();
    t_mm();
    finish_test();
  end
endmodule : bpwu_top_tb
`default_nettype wire
